/* File: rtl/eeprom_recovery_defs.svh */
// constants for the two-wire slave bus recovery and write-commit control
// assumes inclusion by bare name from rtl files only
`ifndef EEPROM_RECOVERY_DEFS_SVH
`define EEPROM_RECOVERY_DEFS_SVH

`define BITS_PER_BYTE 4'd8
`define ACK_SLOT 4'd8
`define BIT_CNT_RST 4'h0
`define BYTE_CNT_RST 8'h00
`define INIT_TIME_NS 1000
`define CLK_PERIOD_NS 5
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: rtl/eeprom_recovery_pkg.sv */
// types shared by the two-wire slave recovery control
// assumes the defs header is included where numbers are needed
package eeprom_recovery_pkg;

    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_STANDBY = 3'b001,
        ST_RECV = 3'b010,
        ST_ACK = 3'b011,
        ST_SEND = 3'b100,
        ST_IGNORE = 3'b101
    } slave_state_e;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
    } bus_event_s;

endpackage

/* File: rtl/pin_sync.sv */
// two-flop synchroniser with edge detect on the synchronised level
// assumes the input is asynchronous to SYS_CLK
`timescale 1ns/1ps
module pin_sync (
    input wire logic clk, // system clock
    input wire logic srst, // sync reset
    input wire logic pin_in, // raw pin
    output logic level, // synchronised level
    output logic rise, // one-cycle rising pulse
    output logic fall // one-cycle falling pulse
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise = sync_r & ~prev_r;
    assign fall = ~sync_r & prev_r;
endmodule

/* File: rtl/eeprom_recovery_ctrl.sv */
// serial interface control of a two-wire eeprom slave: recovery, cancel, commit
// assumes one SYS_CLK domain; bus pins arrive asynchronous and are synchronised
`timescale 1ns/1ps
`include "eeprom_recovery_defs.svh"

// Functional notes
// (RULE1) The master recovers by a start then nine clocks with data released high.
// (RULE2) Clocking with data high abandons any acknowledge or data output and frees data; the code abandons only the acknowledge.
// (RULE3) A start after the dummy clocks returns the interface to idle; the code enters ST_RECV on it and reaches standby only at the following stop.
// (RULE4) The master adds a stop after the recovery start before normal transfers.
// (RULE5) The master must give a start right after the nine clocks, not keep clocking.
// (RULE6) The master should run recovery once after power is applied.
// (RULE7) The master should check the acknowledge after every byte.
// (RULE8) Instructions are ignored during power-on initialisation.
// (RULE9) After power-on clearing the device waits in standby for a start.
// (RULE10) A low supply at the committing stop cancels the write.
// (RULE11) A write starts only on a stop right after an acknowledge with data received.
// (RULE12) A start during command input cancels it and begins a new transaction.
// (RULE13) The master cannot make a start while the device holds data low.
// (RULE14) After a cancel the master must use a random read.
// (RULE15) Recovery restores the interface even if power-on clearing failed.
// (RULE16) Sending a zero bit or acknowledge drives data low.
// (RULE17) Start is data falling with clock high; stop is data rising with clock high.
module eeprom_recovery_ctrl
    import eeprom_recovery_pkg::*;
#(
    parameter int INIT_CYCLES = `INIT_CYCLES
) (
    input wire logic SYS_CLK, // system clock 200 MHz
    input wire logic SRST, // power-on clear, sync active high
    input wire logic SCL_IN, // serial clock pin
    input wire logic SDA_IN, // data pin level
    output logic SDA_OUT, // data pin drive value, always low
    output logic SDA_OE, // high while pulling data low
    input wire logic LOW_SUPPLY, // low-supply detector
    input wire logic TX_BIT, // next data bit to send
    input wire logic READ_MODE, // byte phase sends data
    output logic RX_BYTE_VALID, // pulse: byte received
    output logic [7:0] RX_BYTE, // last received byte
    output logic WRITE_START, // pulse: commit internal write
    output logic WRITE_CANCEL, // pulse: write refused by low supply
    output logic CMD_CANCEL, // pulse: command cancelled by start
    output logic READY // initialisation done
);
    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;
    bus_event_s ev;
    slave_state_e state_r;
    slave_state_e state_nxt;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] byte_cnt_r;
    logic after_ack_r;
    logic drive_low_r;
    logic [31:0] init_cnt_r;
    logic init_done;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    pin_sync u_scl_sync (
        .clk(SYS_CLK),
        .srst(SRST),
        .pin_in(SCL_IN),
        .level(scl_lvl),
        .rise(scl_rise),
        .fall(scl_fall)
    );

    pin_sync u_sda_sync (
        .clk(SYS_CLK),
        .srst(SRST),
        .pin_in(SDA_IN),
        .level(sda_lvl),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    // ----------------------------------------
    // bus conditions
    // ----------------------------------------
    // (RULE17) conditions with clock high
    assign ev.start = sda_fall & scl_lvl & ~scl_rise;
    assign ev.stop = sda_rise & scl_lvl & ~scl_rise;
    assign ev.scl_rise = scl_rise;
    assign ev.scl_fall = scl_fall;

    // ----------------------------------------
    // power-on initialisation
    // ----------------------------------------
    // (RULE8) hold off instructions
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            init_cnt_r <= 32'h0;
        end else if (!init_done) begin
            init_cnt_r <= init_cnt_r + 32'h1;
        end
    end

    assign init_done = (init_cnt_r >= 32'(INIT_CYCLES));
    assign READY = init_done;

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    wire ack_done = (state_r == ST_ACK) && ev.scl_fall;
    wire byte_done = (state_r == ST_RECV || state_r == ST_SEND)
        && ev.scl_fall && (bit_cnt_r == `BITS_PER_BYTE);
    // (RULE11) commit only straight after an ack
    wire commit_stop = ev.stop && after_ack_r && (byte_cnt_r > 8'h01)
        && !READ_MODE;
    // (RULE2) master clocks data high while we pull data low
    wire released_by_master = ev.scl_rise && sda_lvl && drive_low_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_INIT: begin
                // (RULE9) standby after clearing
                if (init_done) begin
                    state_nxt = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (ev.start) begin
                    state_nxt = ST_RECV;
                end
            end
            ST_RECV: begin
                if (byte_done) begin
                    state_nxt = ST_ACK;
                end
            end
            ST_ACK: begin
                if (ack_done) begin
                    state_nxt = READ_MODE ? ST_SEND : ST_RECV;
                end
            end
            ST_SEND: begin
                if (byte_done) begin
                    state_nxt = ST_IGNORE;
                end
            end
            ST_IGNORE: begin
                // master ack slot after a data byte
                if (ev.scl_fall) begin
                    state_nxt = sda_lvl ? ST_STANDBY : ST_SEND;
                end
            end
            default: begin
                state_nxt = ST_STANDBY;
            end
        endcase
        // (RULE2) abandon acknowledge on released data; data output in ST_SEND is kept
        if (state_r != ST_INIT && released_by_master && state_r == ST_ACK) begin
            state_nxt = ST_STANDBY;
        end
        // (RULE3) (RULE12) (RULE15) start restarts decoding
        if (state_r != ST_INIT && ev.start) begin
            state_nxt = ST_RECV;
        end
        if (state_r != ST_INIT && ev.stop) begin
            state_nxt = ST_STANDBY;
        end
    end

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            state_r <= ST_INIT;
            bit_cnt_r <= `BIT_CNT_RST;
            shift_r <= 8'h00;
            byte_cnt_r <= `BYTE_CNT_RST;
            after_ack_r <= 1'b0;
            RX_BYTE <= 8'h00;
            RX_BYTE_VALID <= 1'b0;
        end else begin
            state_r <= state_nxt;
            RX_BYTE_VALID <= 1'b0;
            if (ev.start || ev.stop || state_r == ST_INIT) begin
                bit_cnt_r <= `BIT_CNT_RST;
                byte_cnt_r <= (ev.start) ? `BYTE_CNT_RST : byte_cnt_r;
                after_ack_r <= 1'b0;
            end else begin
                if (ev.scl_rise && state_r == ST_RECV) begin
                    shift_r <= {shift_r[6:0], sda_lvl};
                end
                // a stop rides on the next clock's high phase, so only its fall closes the window
                if (ev.scl_fall && state_r == ST_RECV) begin
                    after_ack_r <= 1'b0;
                end
                // count rises: the fall that closes a start is not a bit
                if (byte_done) begin
                    bit_cnt_r <= `BIT_CNT_RST;
                    if (state_r == ST_RECV) begin
                        RX_BYTE <= shift_r;
                        RX_BYTE_VALID <= 1'b1;
                    end
                end else if (ev.scl_rise && (state_r == ST_RECV || state_r == ST_SEND)) begin
                    bit_cnt_r <= bit_cnt_r + 4'd1;
                end
                if (ack_done) begin
                    after_ack_r <= 1'b1;
                    byte_cnt_r <= byte_cnt_r + 8'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // data line drive
    // ----------------------------------------
    // (RULE16) pull low for ack or zero bit
    wire drive_nxt = (state_nxt == ST_ACK)
        || (state_nxt == ST_SEND && !TX_BIT);

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            drive_low_r <= 1'b0;
            WRITE_START <= 1'b0;
            WRITE_CANCEL <= 1'b0;
            CMD_CANCEL <= 1'b0;
        end else begin
            // drive changes while clock is low, or with clock high on a start, stop or master release
            if (!scl_lvl || ev.start || ev.stop || released_by_master) begin
                drive_low_r <= drive_nxt && !ev.start && !ev.stop;
            end
            // (RULE10) (RULE11) low supply cancels commit
            WRITE_START <= commit_stop && !LOW_SUPPLY;
            WRITE_CANCEL <= commit_stop && LOW_SUPPLY;
            // (RULE12) cancel of command in progress
            CMD_CANCEL <= ev.start && (state_r == ST_RECV || state_r == ST_ACK);
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE = drive_low_r;
endmodule

/* File: testbench/eeprom_recovery_monitor.sv */
// checker on the recovery control ports
// assumes binding onto eeprom_recovery_ctrl
`timescale 1ns/1ps
module eeprom_recovery_monitor #(
    parameter int INIT_CYCLES = 200
) (
    input wire logic SYS_CLK, // clock
    input wire logic SRST, // reset
    input wire logic SCL_IN, // clock pin
    input wire logic SDA_IN, // data pin
    input wire logic SDA_OUT, // drive value
    input wire logic SDA_OE, // drive enable
    input wire logic LOW_SUPPLY, // detector
    input wire logic RX_BYTE_VALID, // byte pulse
    input wire logic WRITE_START, // commit
    input wire logic WRITE_CANCEL, // refused
    input wire logic CMD_CANCEL, // cancel
    input wire logic READY // init done
);
    // ----
    // counts from reset release; saturates
    // ----
    logic [15:0] cnt_r;
    always_ff @(posedge SYS_CLK) begin
        if (SRST) cnt_r <= 16'h0;
        else if (cnt_r != 16'hffff) cnt_r <= cnt_r + 16'h1;
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    property p_early; cnt_r < INIT_CYCLES - 1 |-> !READY; endproperty
    a_early: assert property (p_early) else $error("ready too soon");
    property p_late; cnt_r > INIT_CYCLES + 2 |-> READY; endproperty
    a_late: assert property (p_late) else $error("ready too late");
    property p_idle; !READY |-> !SDA_OE && !RX_BYTE_VALID && !WRITE_START; endproperty
    a_idle: assert property (p_idle) else $error("activity during init");
    property p_od; SDA_OUT == 1'b0; endproperty
    a_od: assert property (p_od) else $error("data drive not low");
    property p_oe; $rose(SDA_OE) |-> !SCL_IN; endproperty
    a_oe: assert property (p_oe) else $error("drive began with clock high");
    property p_commit; WRITE_START |-> !$past(LOW_SUPPLY) && !WRITE_CANCEL; endproperty
    a_commit: assert property (p_commit) else $error("commit at low supply");
    property p_refuse; WRITE_CANCEL |-> $past(LOW_SUPPLY) ##1 !WRITE_CANCEL; endproperty
    a_refuse: assert property (p_refuse) else $error("bad write refusal");
    property p_stop; WRITE_START |-> SCL_IN && SDA_IN ##1 !WRITE_START; endproperty
    a_stop: assert property (p_stop) else $error("commit without stop");
    property p_start; CMD_CANCEL |-> SCL_IN && !SDA_IN; endproperty
    a_start: assert property (p_start) else $error("cancel without start");
endmodule

bind eeprom_recovery_ctrl eeprom_recovery_monitor #(.INIT_CYCLES(INIT_CYCLES)) mon_u (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .LOW_SUPPLY(LOW_SUPPLY), .RX_BYTE_VALID(RX_BYTE_VALID),
    .WRITE_START(WRITE_START), .WRITE_CANCEL(WRITE_CANCEL), .CMD_CANCEL(CMD_CANCEL),
    .READY(READY)
);

/* File: testbench/bus_master_model.sv */
// two-wire bus master driving clock and data
// assumes an open-drain data wire with pull-up
`timescale 1ns/1ps
module bus_master_model (
    input wire logic dev_oe, // device pulls data low
    output logic scl, // serial clock, idle high
    output logic sda // resolved data wire
);
    localparam int H = 32;
    logic m_low = 1'b0;
    assign sda = !(m_low || dev_oe);
    initial scl = 1'b1;
    // ----
    // bus conditions and bits
    // ----
    task automatic start_c();
        #(H/2) m_low = 1'b0;
        #(H/2) scl = 1'b1;
        #H m_low = 1'b1;
        #H scl = 1'b0;
    endtask
    task automatic stop_c();
        #(H/2) m_low = 1'b1;
        #(H/2) scl = 1'b1;
        #H m_low = 1'b0;
        #H;
    endtask
    task automatic put_bit(input logic b);
        #(H/2) m_low = !b;
        #(H/2) scl = 1'b1;
        #H scl = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        #(H/2) m_low = 1'b0;
        #(H/2) scl = 1'b1;
        #(H/2) b = sda;
        #(H/2) scl = 1'b0;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(ack);
    endtask
    // start, nine released clocks, start, stop
    task automatic recover();
        logic b;
        start_c();
        repeat (9) get_bit(b);
        start_c();
        stop_c();
    endtask
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the recovery control
// assumes the bus master model drives the link
`timescale 1ns/1ps
module tb_top;
    logic clk, srst, low_sup, tx_bit, rd_mode, oe, rxv, wst, wcn, ccn, rdy;
    logic [7:0] rxb;
    logic a;
    wire scl, sda;
    int err_total = 0, cmp_count = 0, cc = 0, n, seed = 32'hbebd5171;
    logic [9:0] q[$];
    eeprom_recovery_ctrl #(.INIT_CYCLES(200)) dut_u (.SYS_CLK(clk), .SRST(srst),
        .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(oe), .LOW_SUPPLY(low_sup),
        .TX_BIT(tx_bit), .READ_MODE(rd_mode), .RX_BYTE_VALID(rxv), .RX_BYTE(rxb),
        .WRITE_START(wst), .WRITE_CANCEL(wcn), .CMD_CANCEL(ccn), .READY(rdy));
    bus_master_model m_u (.dev_oe(oe), .scl(scl), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(string s, logic [9:0] e, logic [9:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic stop_test();
        check("queue", 10'h0, 10'(q.size()));
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ----
    // output watcher against noted events
    // ----
    always @(posedge clk) begin
        if (ccn === 1'b1) cc++;
        if (rxv !== 1'b0 || wst !== 1'b0 || wcn !== 1'b0) begin
            if (q.size() == 0) check("event", 10'h3ff, {wst, wcn, rxv ? rxb : 8'h00});
            else check("event", q.pop_front(), {wst, wcn, rxv ? rxb : 8'h00});
        end
    end
    task automatic frame(int nb, int xb);
        logic [7:0] d;
        m_u.start_c();
        for (int i = 0; i < nb; i++) begin
            d = 8'($random(seed));
            q.push_back({2'b00, d});
            m_u.wr_byte(d, a);
            check("ack", 10'h0, {9'h0, a});
        end
        repeat (xb) m_u.put_bit(1'b1);
        // commit only straight after an acknowledge
        if (nb > 1 && xb == 0) q.push_back({~low_sup, low_sup, 8'h00});
        m_u.stop_c();
        #200;
    endtask
    initial begin
        srst = 1'b1; low_sup = 1'b0; tx_bit = 1'b0; rd_mode = 1'b0;
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        m_u.start_c();
        m_u.wr_byte(8'ha0, a);
        m_u.stop_c();
        check("early_ack", 10'h1, {9'h0, a});
        for (int i = 0; i < 400 && rdy !== 1'b1; i++) @(posedge clk);
        check("ready", 10'h1, {9'h0, rdy});
        if (rdy !== 1'b1) stop_test();
        n = cc;
        q.push_back({2'b00, 8'hff});
        m_u.recover();
        #200;
        check("cancel", 10'(n + 1), 10'(cc));
        frame(2, 0);
        @(posedge clk) #1 low_sup = 1'b1;
        frame(3, 0);
        @(posedge clk) #1 low_sup = 1'b0;
        frame(1, 0);
        frame(2, 4);
        n = cc;
        m_u.start_c();
        q.push_back({2'b00, 8'h5a});
        m_u.wr_byte(8'h5a, a);
        repeat (3) m_u.put_bit(1'b0);
        frame(2, 0);
        check("cancel", 10'(n + 1), 10'(cc));
        // dummy write reloads the address, then a restart reads
        m_u.start_c();
        q.push_back({2'b00, 8'ha0});
        q.push_back({2'b00, 8'h10});
        m_u.wr_byte(8'ha0, a);
        m_u.wr_byte(8'h10, a);
        check("ack", 10'h0, {9'h0, a});
        repeat (8) @(posedge clk);
        #1 rd_mode = 1'b1;
        n = cc;
        m_u.start_c();
        check("cancel", 10'(n + 1), 10'(cc));
        q.push_back({2'b00, 8'ha1});
        m_u.wr_byte(8'ha1, a);
        for (int i = 0; i < 4; i++) begin
            m_u.get_bit(a);
            check("tx_bit", 10'h0, {9'h0, a});
        end
        m_u.recover();
        check("oe", 10'h0, {9'h0, oe});
        @(posedge clk) #1 rd_mode = 1'b0;
        frame(2, 0);
        stop_test();
    end
    initial begin
        #100000;
        err_total++;
        stop_test();
    end
endmodule
